//--- core/umaf_pkg.sv
// Package for the multidrop address filter of the serial receiver.
// Assumes a receiver on the same clock that hands over one frame at a time.
package umaf_pkg;

    // ========================================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] UMAF_IDX_CTRL = 8'h00;
    localparam logic [7:0] UMAF_IDX_RXDATA = 8'h01;
    localparam logic [7:0] UMAF_IDX_IRQ_STAT = 8'h02;
    localparam logic [7:0] UMAF_IDX_IRQ_MASK = 8'h03;
    localparam logic [7:0] UMAF_IDX_NODE_ADDR = 8'hA9;
    localparam logic [7:0] UMAF_IDX_NODE_MASK = 8'hB9;
    localparam int UMAF_IDX_SHIFT = 2;

    // ========================================================================
    // Field positions and reset values
    localparam int UMAF_CTRL_MODE_LSB = 0;
    localparam int UMAF_CTRL_FILT_BIT = 2;
    localparam int UMAF_RX_NINTH_BIT = 8;
    localparam int UMAF_RX_FLAG_BIT = 9;
    localparam int UMAF_IRQ_W = 3;
    localparam int UMAF_EV_ACCEPT = 0;
    localparam int UMAF_EV_FILTERED = 1;
    localparam int UMAF_EV_BUSY = 2;
    localparam logic [7:0] UMAF_ADDR_RESET = 8'h00;
    localparam logic [1:0] UMAF_RESP_OKAY = 2'b00;
    localparam logic [1:0] UMAF_RESP_SLVERR = 2'b10;

    // ========================================================================
    // Frame modes and register selection
    typedef enum logic [1:0] {
        UMAF_MODE_SYNC8,
        UMAF_MODE_ASYNC10,
        UMAF_MODE_ASYNC11_FIXED,
        UMAF_MODE_ASYNC11_VAR
    } umaf_mode_t;

    typedef enum logic [2:0] {
        UMAF_SEL_CTRL,
        UMAF_SEL_RXDATA,
        UMAF_SEL_IRQ_STAT,
        UMAF_SEL_IRQ_MASK,
        UMAF_SEL_NODE_ADDR,
        UMAF_SEL_NODE_MASK,
        UMAF_SEL_NONE
    } umaf_sel_t;

    // One received frame: ninth holds the 9th bit, or the stop bit in mode 1
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
    } umaf_frame_t;

endpackage

//--- core/umaf_addr_filter.sv
// Multidrop address recognition and receive buffer, with an AXI4-Lite slave.
// Assumes the receiver delivers frames as a one-cycle pulse on aclk.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module umaf_addr_filter
    import umaf_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Frames from the receiver
    input wire logic frame_valid,
    input wire umaf_pkg::umaf_frame_t frame_in,
    // Status out
    output logic rx_complete_flag,
    output logic irq
);
    import umaf_pkg::*;

    // ========================================================================
    // Helpers
    function automatic umaf_sel_t decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[UMAF_IDX_SHIFT +: 8];
        if (addr[UMAF_IDX_SHIFT-1:0] != '0)
            return UMAF_SEL_NONE;
        if (ADDR_W > UMAF_IDX_SHIFT + 8 && (addr >> (UMAF_IDX_SHIFT + 8)) != '0)
            return UMAF_SEL_NONE;
        unique case (idx)
            UMAF_IDX_CTRL: return UMAF_SEL_CTRL;
            UMAF_IDX_RXDATA: return UMAF_SEL_RXDATA;
            UMAF_IDX_IRQ_STAT: return UMAF_SEL_IRQ_STAT;
            UMAF_IDX_IRQ_MASK: return UMAF_SEL_IRQ_MASK;
            UMAF_IDX_NODE_ADDR: return UMAF_SEL_NODE_ADDR;
            UMAF_IDX_NODE_MASK: return UMAF_SEL_NODE_MASK;
            default: return UMAF_SEL_NONE;
        endcase
    endfunction

    // ========================================================================
    // State
    logic [7:0] node_address_ff;
    logic [7:0] node_address_mask_ff;
    umaf_mode_t mode_ff;
    logic addr_filter_enable_ff;
    logic [7:0] serial_buffer_ff;
    logic rx_ninth_bit_ff;
    logic rx_complete_flag_ff;
    logic [UMAF_IRQ_W-1:0] irq_stat_ff;
    logic [UMAF_IRQ_W-1:0] irq_mask_ff;
    logic irq_ff;

    logic aw_held_ff;
    logic w_held_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // ========================================================================
    // Address match and acceptance
    logic [7:0] bcast_bits;
    logic given_hit;
    logic bcast_hit;
    logic filt_mode;
    logic filt_on;
    logic frame_ok;
    logic accept;

    assign bcast_bits = node_address_ff | node_address_mask_ff;
    assign given_hit = ((frame_in.data ^ node_address_ff) & node_address_mask_ff) == 8'h00;
    assign bcast_hit = (frame_in.data & bcast_bits) == bcast_bits;
    // Mode 0 has no ninth or stop bit to qualify, so the filter stays out of it
    assign filt_mode = mode_ff != UMAF_MODE_SYNC8;
    assign filt_on = addr_filter_enable_ff && filt_mode;
    // Address frame carries ninth bit 1; data frames are refused while filtering
    assign frame_ok = !filt_on || (frame_in.ninth && (given_hit || bcast_hit));
    assign accept = frame_valid && !rx_complete_flag_ff && frame_ok;

    // ========================================================================
    // Write decode
    logic wr_fire;
    umaf_sel_t wr_sel;
    umaf_sel_t rd_sel;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
    assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
    assign wr_fire = (aw_held_ff || (s_axi_awvalid && awready_ff))
        && (w_held_ff || (s_axi_wvalid && wready_ff)) && !bvalid_ff;
    assign wr_sel = decode(wr_addr);
    assign rd_sel = decode(s_axi_araddr);

    logic wr_lo;
    logic wr_hi;
    assign wr_lo = wr_fire && wr_strb[0];
    assign wr_hi = wr_fire && wr_strb[1];

    // ========================================================================
    // Software registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            node_address_ff <= UMAF_ADDR_RESET;
            node_address_mask_ff <= UMAF_ADDR_RESET;
        end
        else if (wr_lo && wr_sel == UMAF_SEL_NODE_ADDR)
            node_address_ff <= wr_data[7:0];
        else if (wr_lo && wr_sel == UMAF_SEL_NODE_MASK)
            node_address_mask_ff <= wr_data[7:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_ff <= UMAF_MODE_SYNC8;
            addr_filter_enable_ff <= 1'b0;
            irq_mask_ff <= '0;
        end
        else if (wr_lo && wr_sel == UMAF_SEL_CTRL)
        begin
            mode_ff <= umaf_mode_t'(wr_data[UMAF_CTRL_MODE_LSB +: 2]);
            addr_filter_enable_ff <= wr_data[UMAF_CTRL_FILT_BIT];
        end
        else if (wr_lo && wr_sel == UMAF_SEL_IRQ_MASK)
            irq_mask_ff <= wr_data[UMAF_IRQ_W-1:0];
    end

    // ========================================================================
    // Receive buffer, ninth bit and completion flag
    logic flag_clr;
    assign flag_clr = wr_hi && wr_sel == UMAF_SEL_RXDATA && wr_data[UMAF_RX_FLAG_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            serial_buffer_ff <= 8'h00;
            rx_ninth_bit_ff <= 1'b0;
        end
        else if (accept)
        begin
            serial_buffer_ff <= frame_in.data;
            // Mode 1 keeps the stop bit here; mode 0 has none
            rx_ninth_bit_ff <= filt_mode ? frame_in.ninth : 1'b0;
        end
    end

    // A frame landing on the clearing write while the flag is set is dropped as busy, and the flag clears
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rx_complete_flag_ff <= 1'b0;
        else if (accept)
            rx_complete_flag_ff <= 1'b1;
        else if (flag_clr)
            rx_complete_flag_ff <= 1'b0;
    end

    // ========================================================================
    // Interrupt status, mask and output
    logic [UMAF_IRQ_W-1:0] ev;
    logic [UMAF_IRQ_W-1:0] irq_clr;
    always_comb
    begin
        ev = '0;
        ev[UMAF_EV_ACCEPT] = accept;
        ev[UMAF_EV_FILTERED] = frame_valid && !frame_ok;
        ev[UMAF_EV_BUSY] = frame_valid && frame_ok && rx_complete_flag_ff;
    end
    assign irq_clr = (wr_lo && wr_sel == UMAF_SEL_IRQ_STAT) ? wr_data[UMAF_IRQ_W-1:0] : '0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_stat_ff <= '0;
        else
            irq_stat_ff <= ev | (irq_stat_ff & ~irq_clr);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end

    // ========================================================================
    // AXI4-Lite write path: address and data may come in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= UMAF_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= (wr_sel == UMAF_SEL_NONE) ? UMAF_RESP_SLVERR : UMAF_RESP_OKAY;
        end
        else if (bvalid_ff)
        begin
            if (s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
        else
        begin
            if (s_axi_awvalid && awready_ff)
            begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                awready_ff <= 1'b0;
            end
            else if (!aw_held_ff)
                awready_ff <= 1'b1;
            if (s_axi_wvalid && wready_ff)
            begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                wready_ff <= 1'b0;
            end
            else if (!w_held_ff)
                wready_ff <= 1'b1;
        end
    end

    // ========================================================================
    // AXI4-Lite read path
    logic [31:0] rd_word;
    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (rd_sel)
            UMAF_SEL_CTRL:
            begin
                rd_word[UMAF_CTRL_MODE_LSB +: 2] = mode_ff;
                rd_word[UMAF_CTRL_FILT_BIT] = addr_filter_enable_ff;
            end
            UMAF_SEL_RXDATA:
            begin
                rd_word[7:0] = serial_buffer_ff;
                rd_word[UMAF_RX_NINTH_BIT] = rx_ninth_bit_ff;
                rd_word[UMAF_RX_FLAG_BIT] = rx_complete_flag_ff;
            end
            UMAF_SEL_IRQ_STAT: rd_word[UMAF_IRQ_W-1:0] = irq_stat_ff;
            UMAF_SEL_IRQ_MASK: rd_word[UMAF_IRQ_W-1:0] = irq_mask_ff;
            UMAF_SEL_NODE_ADDR: rd_word[7:0] = node_address_ff;
            UMAF_SEL_NODE_MASK: rd_word[7:0] = node_address_mask_ff;
            UMAF_SEL_NONE: rd_word = 32'h0000_0000;
        endcase
    end

    // Reads are side-effect free, so outside reset the flag only drops on a write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= UMAF_RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_ff)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= (rd_sel == UMAF_SEL_NONE) ? UMAF_RESP_SLVERR : UMAF_RESP_OKAY;
        end
        else if (rvalid_ff)
        begin
            if (s_axi_rready)
            begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
        else
            arready_ff <= 1'b1;
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign rx_complete_flag = rx_complete_flag_ff;
    assign irq = irq_ff;

    // ========================================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking

    sequence s_free_frame;
        frame_valid && !rx_complete_flag_ff && !flag_clr;
    endsequence

    sequence s_filtering;
        addr_filter_enable_ff && mode_ff != UMAF_MODE_SYNC8;
    endsequence

    a_open_accepts_all: assert property (disable iff (!aresetn)
        s_free_frame and !addr_filter_enable_ff |=> rx_complete_flag_ff && serial_buffer_ff == $past(frame_in.data))
        else $error("frame lost with filter off");

    a_sync_mode_open: assert property (disable iff (!aresetn)
        s_free_frame and mode_ff == UMAF_MODE_SYNC8 |=> rx_complete_flag_ff)
        else $error("mode 0 frame filtered");

    a_data_frame_drop: assert property (disable iff (!aresetn)
        s_free_frame and s_filtering and !frame_in.ninth |=> !rx_complete_flag_ff)
        else $error("data frame accepted while filtering");

    a_mode1_stop_gate: assert property (disable iff (!aresetn)
        s_free_frame and addr_filter_enable_ff && mode_ff == UMAF_MODE_ASYNC10
        && !frame_in.ninth |=> !rx_complete_flag_ff && $stable(serial_buffer_ff))
        else $error("mode 1 frame with zero stop accepted");

    a_given_match: assert property (disable iff (!aresetn)
        s_free_frame and s_filtering and frame_in.ninth
        and ((frame_in.data ^ node_address_ff) & node_address_mask_ff) == 8'h00
        |=> rx_complete_flag_ff)
        else $error("given address not accepted");

    a_bcast_match: assert property (disable iff (!aresetn)
        s_free_frame and s_filtering and frame_in.ninth
        and (frame_in.data & (node_address_ff | node_address_mask_ff))
        == (node_address_ff | node_address_mask_ff) |=> rx_complete_flag_ff)
        else $error("broadcast address not accepted");

    a_no_match_drop: assert property (disable iff (!aresetn)
        s_free_frame and s_filtering and !given_hit and !bcast_hit
        |=> !rx_complete_flag_ff)
        else $error("unmatched address accepted");

    a_busy_holds: assert property (disable iff (!aresetn)
        frame_valid && rx_complete_flag_ff |=> $stable(serial_buffer_ff) && $stable(rx_ninth_bit_ff))
        else $error("buffer overwritten while flag set");

    a_ninth_kept: assert property (disable iff (!aresetn)
        accept && (mode_ff == UMAF_MODE_ASYNC11_FIXED || mode_ff == UMAF_MODE_ASYNC11_VAR)
        |=> rx_ninth_bit_ff == $past(frame_in.ninth))
        else $error("ninth bit not stored");

    a_reset_addr: assert property (
        !aresetn |=> node_address_ff == 8'h00 && node_address_mask_ff == 8'h00)
        else $error("address registers not cleared by reset");

    a_node_write: assert property (disable iff (!aresetn)
        wr_fire && wr_strb[0] && decode(wr_addr) == UMAF_SEL_NODE_ADDR
        |=> node_address_ff == $past(wr_data[7:0]))
        else $error("node address write lost");

    a_map_place: assert property (disable iff (!aresetn)
        wr_fire && wr_strb[0] && wr_addr == ADDR_W'({UMAF_IDX_NODE_MASK, 2'b00})
        |=> node_address_mask_ff == $past(wr_data[7:0]))
        else $error("mask register not at its index");

    a_ninth_gate: assert property (disable iff (!aresetn)
        accept && filt_on |-> frame_in.ninth)
        else $error("accepted frame with low ninth bit");

    a_match_form: assert property (disable iff (!aresetn)
        accept && filt_on |-> given_hit || bcast_hit)
        else $error("accepted frame without a match");

endmodule

`default_nettype wire

//--- verif/umaf_master_model.sv
// Frame source that stands in for the master on the shared serial line.
// Assumes one clock; each frame reaches the receiver as a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none

module umaf_master_model
    import umaf_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Frames towards the filter
    output logic frame_valid,
    output var umaf_pkg::umaf_frame_t frame_in
);
    import umaf_pkg::*;

    initial
    begin
        frame_valid = 1'b0;
        frame_in = '0;
    end

    // ========================================================================
    // One frame after gap+1 idle cycles; gap 0 still leaves one idle cycle between frames
    task automatic send(input umaf_frame_t fr, input int gap);
        repeat (gap) @(posedge aclk);
        @(posedge aclk);
        frame_valid <= 1'b1;
        frame_in <= fr;
        @(posedge aclk);
        frame_valid <= 1'b0;
        // Idle line must not keep showing the last frame
        frame_in <= ~fr;
    endtask
endmodule
`default_nettype wire

//--- verif/test_uart_multidrop_addr_filter.sv
// Self-checking bench for the multidrop address filter.
// Assumes the filter answers AXI4-Lite and takes frames from the master model.
`timescale 1ns/1ps
`default_nettype none

module test_uart_multidrop_addr_filter;
    import umaf_pkg::*;

    localparam logic [11:0] ad_ctrl = 12'(UMAF_IDX_CTRL) << UMAF_IDX_SHIFT;
    localparam logic [11:0] ad_rx = 12'(UMAF_IDX_RXDATA) << UMAF_IDX_SHIFT;
    localparam logic [11:0] ad_stat = 12'(UMAF_IDX_IRQ_STAT) << UMAF_IDX_SHIFT;
    localparam logic [11:0] ad_msk = 12'(UMAF_IDX_IRQ_MASK) << UMAF_IDX_SHIFT;
    localparam logic [11:0] ad_node = 12'(UMAF_IDX_NODE_ADDR) << UMAF_IDX_SHIFT;
    localparam logic [11:0] ad_nmask = 12'(UMAF_IDX_NODE_MASK) << UMAF_IDX_SHIFT;

    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, frame_valid, rx_complete_flag, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    umaf_frame_t frame_in;
    int n_errors = 0;
    int checks = 0;

    umaf_addr_filter #(.ADDR_W(12)) i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_valid(frame_valid),
        .frame_in(frame_in), .rx_complete_flag(rx_complete_flag), .irq(irq)
    );

    umaf_master_model i_master (
        .aclk(aclk), .frame_valid(frame_valid), .frame_in(frame_in)
    );

    // ========================================================================
    // Reporting
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic hang(input string nm);
        n_errors++;
        $display("unexpected %s: expected answer within bound, seen none", nm);
        print_verdict();
    endtask

    // ========================================================================
    // AXI4-Lite master; both lanes enabled so the flag clear in lane 1 lands
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) hang("write response");
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) hang("read response");
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
    endtask

    // ========================================================================
    // One frame under a mode and filter setting, then clear flag and events
    task automatic frame_case(input logic [1:0] m, input logic f, input logic [8:0] fr,
                              input logic acc);
        logic [31:0] exp_rx;
        exp_rx = {22'h0, 1'b1, (m == 2'h0) ? 1'b0 : fr[0], fr[8:1]};
        axi_wr(ad_ctrl, {29'h0, f, m}, UMAF_RESP_OKAY);
        axi_rd(ad_ctrl, {29'h0, f, m}, UMAF_RESP_OKAY);
        i_master.send(fr, 1);
        #1;
        chk("rx_complete_flag", 32'(acc), 32'(rx_complete_flag));
        if (acc) axi_rd(ad_rx, exp_rx, UMAF_RESP_OKAY);
        axi_rd(ad_stat, acc ? 32'h0000_0001 : 32'h0000_0002, UMAF_RESP_OKAY);
        axi_wr(ad_rx, 32'h0000_0200, UMAF_RESP_OKAY);
        axi_wr(ad_stat, 32'h0000_0007, UMAF_RESP_OKAY);
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'h3;
        aresetn = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(ad_node, 32'h0000_0000, UMAF_RESP_OKAY);
        axi_rd(ad_nmask, 32'h0000_0000, UMAF_RESP_OKAY);
        axi_rd(ad_msk, 32'h0000_0000, UMAF_RESP_OKAY);
        axi_rd(12'h010, 32'h0000_0000, UMAF_RESP_SLVERR);
        axi_wr(12'h2A5, 32'h0000_0055, UMAF_RESP_SLVERR);
        frame_case(2'h2, 1'b1, {8'h5A, 1'b1}, 1'b1);
        axi_wr(ad_node, 32'h0000_00A4, UMAF_RESP_OKAY);
        axi_wr(ad_nmask, 32'h0000_00FA, UMAF_RESP_OKAY);
        axi_rd(ad_node, 32'h0000_00A4, UMAF_RESP_OKAY);
        axi_rd(ad_nmask, 32'h0000_00FA, UMAF_RESP_OKAY);
        // Given address 1010_0x0x, broadcast 1111_111x
        frame_case(2'h2, 1'b1, {8'hA0, 1'b1}, 1'b1);
        frame_case(2'h3, 1'b1, {8'hA1, 1'b1}, 1'b1);
        frame_case(2'h3, 1'b1, {8'hA2, 1'b1}, 1'b0);
        frame_case(2'h2, 1'b1, {8'hA5, 1'b1}, 1'b1);
        frame_case(2'h2, 1'b1, {8'hFE, 1'b1}, 1'b1);
        frame_case(2'h3, 1'b1, {8'h7F, 1'b1}, 1'b0);
        frame_case(2'h2, 1'b1, {8'hA0, 1'b0}, 1'b0);
        frame_case(2'h2, 1'b0, {8'h55, 1'b0}, 1'b1);
        frame_case(2'h3, 1'b0, {8'h33, 1'b1}, 1'b1);
        frame_case(2'h1, 1'b1, {8'hA0, 1'b1}, 1'b1);
        frame_case(2'h1, 1'b1, {8'hA0, 1'b0}, 1'b0);
        frame_case(2'h1, 1'b1, {8'h33, 1'b1}, 1'b0);
        frame_case(2'h0, 1'b1, {8'h33, 1'b1}, 1'b1);
        // Second frame while the flag is still set must be lost
        i_master.send({8'h11, 1'b1}, 0);
        i_master.send({8'h22, 1'b0}, 0);
        // Mode 0 keeps no ninth bit, so bit 8 reads back low
        axi_rd(ad_rx, 32'h0000_0211, UMAF_RESP_OKAY);
        axi_rd(ad_stat, 32'h0000_0005, UMAF_RESP_OKAY);
        axi_wr(ad_rx, 32'h0000_0200, UMAF_RESP_OKAY);
        axi_wr(ad_stat, 32'h0000_0007, UMAF_RESP_OKAY);
        // Masked event keeps irq low, unmasked one raises it
        i_master.send({8'h44, 1'b0}, 0);
        repeat (3) @(posedge aclk);
        #1;
        chk("irq", 32'h0000_0000, 32'(irq));
        axi_wr(ad_msk, 32'h0000_0001, UMAF_RESP_OKAY);
        @(posedge aclk);
        #1;
        chk("irq", 32'h0000_0001, 32'(irq));
        axi_wr(ad_stat, 32'h0000_0001, UMAF_RESP_OKAY);
        @(posedge aclk);
        #1;
        chk("irq", 32'h0000_0000, 32'(irq));
        print_verdict();
    end
endmodule
`default_nettype wire
